// ---- core/prcs_link_qual.sv ----
// module: descrambler lock timer and 100 mb/s link qualification
`timescale 1ns/1ps
`default_nettype none
module prcs_link_qual #(
    parameter int unsigned T_SHORT = prcs_pkg::DESC_SHORT_CYC,
    parameter int unsigned T_LONG  = prcs_pkg::DESC_LONG_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic signal_level_valid,
    input  wire logic descr_sync_seen,
    input  wire logic force_signal_detect,
    input  wire logic signal_detect_algorithm,
    input  wire logic descrambler_timeout_select,
    input  wire logic force_good_link,
    output logic      descr_locked,
    output logic      link_ok
);
    localparam int unsigned TW = $clog2(T_LONG + 1);

    typedef struct packed {
        prcs_pkg::prcs_link_t st;
        logic                 locked;
        logic [TW-1:0]        timer;
        logic                 link_ok;
    } prcs_lq_t;

    prcs_lq_t      q;
    prcs_lq_t      n;
    logic          sd;
    logic [TW-1:0] limit;

    // ****************************************************************
    // lock timer and link state
    // ****************************************************************
    always_comb begin
        n     = q;
        sd    = signal_level_valid | force_signal_detect;
        // longer timeout lets jumbo frames pass without losing sync
        limit = descrambler_timeout_select ? TW'(T_LONG - 1) : TW'(T_SHORT - 1);
        if (!sd) begin
            n.locked = 1'b0;
            n.timer  = '0;
        end else if (descr_sync_seen) begin
            n.locked = 1'b1;
            n.timer  = '0;
        end else if (q.locked) begin
            if (q.timer >= limit) begin
                n.locked = 1'b0;
                n.timer  = '0;
            end else begin
                n.timer = q.timer + TW'(1);
            end
        end
        unique case (q.st)
            prcs_pkg::PRCS_LINK_DOWN: begin
                if (sd && q.locked) begin
                    n.st = prcs_pkg::PRCS_LINK_UP;
                end
            end
            prcs_pkg::PRCS_LINK_UP: begin
                if (!sd) begin
                    n.st = prcs_pkg::PRCS_LINK_DOWN;
                end else if (!signal_detect_algorithm && !q.locked) begin
                    n.st = prcs_pkg::PRCS_LINK_DOWN;
                end
            end
        endcase
        n.link_ok = force_good_link | (n.st == prcs_pkg::PRCS_LINK_UP);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign descr_locked = q.locked;
    assign link_ok      = q.link_ok;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_lock_hold_link: assert property (
        q.st == prcs_pkg::PRCS_LINK_UP && signal_detect_algorithm && sd
        |=> q.st == prcs_pkg::PRCS_LINK_UP)
        else $error("link dropped with valid signal in default algorithm");
    a_lock_loss_drop: assert property (
        q.st == prcs_pkg::PRCS_LINK_UP && !signal_detect_algorithm && !q.locked
        |=> q.st == prcs_pkg::PRCS_LINK_DOWN)
        else $error("link kept after lock loss in modified algorithm");
    a_lock_timeout: assert property (
        q.locked && sd && !descr_sync_seen && q.timer >= limit |=> !q.locked)
        else $error("descrambler lock outlived its timeout");
    a_force_good: assert property (
        force_good_link |=> link_ok)
        else $error("forced good link not shown");
    c_link_up: cover property (q.st == prcs_pkg::PRCS_LINK_UP ##1 !link_ok);
endmodule
`default_nettype wire

// ---- core/prcs_pkg.sv ----
// package: register map, field layout, reset values and timing counts of the pcs register bank
package prcs_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned ADDR_W         = 12;
    localparam logic [7:0]  IDX_RX_ERR     = 8'h15;
    localparam logic [7:0]  IDX_PCS_CFG    = 8'h16;
    localparam logic [7:0]  IDX_IRQ_STAT   = 8'h17;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h18;
    localparam logic [11:0] ADR_RX_ERR     = {2'h0, IDX_RX_ERR, 2'h0};
    localparam logic [11:0] ADR_PCS_CFG    = {2'h0, IDX_PCS_CFG, 2'h0};
    localparam logic [11:0] ADR_IRQ_STAT   = {2'h0, IDX_IRQ_STAT, 2'h0};
    localparam logic [11:0] ADR_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};

    // ****************************************************************
    // coding sublayer configuration fields
    // ****************************************************************
    localparam int unsigned CFG_TRUE_QUIET = 10;
    localparam int unsigned CFG_FORCE_SD   = 9;
    localparam int unsigned CFG_SD_ALG     = 8;
    localparam int unsigned CFG_DESC_TMO   = 7;
    localparam int unsigned CFG_FORCE_OK   = 5;
    localparam int unsigned CFG_NRZI_BYP   = 2;
    localparam logic [15:0] CFG_WR_MASK    = 16'h07A4;
    localparam logic [15:0] CFG_RESET      = 16'h0100;
    localparam logic [7:0]  TALLY_MAX      = 8'hFF;

    // ****************************************************************
    // interrupt status bits
    // ****************************************************************
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned IRQ_ERR_COUNT  = 0;
    localparam int unsigned IRQ_ERR_SAT    = 1;
    localparam int unsigned IRQ_LINK_CHG   = 2;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned DESC_SHORT_US  = 722;
    localparam int unsigned DESC_LONG_MS   = 2;
    localparam int unsigned DESC_SHORT_CYC = (DESC_SHORT_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned DESC_LONG_CYC  = (DESC_LONG_MS * 1000000) / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        PRCS_LINK_DOWN = 1'b0,
        PRCS_LINK_UP   = 1'b1
    } prcs_link_t;

endpackage

// ---- core/prcs_top.sv ----
// module: apb register bank with receive error tally and coding sublayer configuration
`timescale 1ns/1ps
`default_nettype none
module prcs_top #(
    parameter int unsigned DESC_SHORT_CYC = prcs_pkg::DESC_SHORT_CYC,
    parameter int unsigned DESC_LONG_CYC  = prcs_pkg::DESC_LONG_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [prcs_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        carrier_valid,
    input  wire logic                        invalid_symbol,
    input  wire logic                        collision,
    input  wire logic                        signal_level_valid,
    input  wire logic                        descr_sync_seen,
    output logic                             true_quiet_enable,
    output logic                             force_signal_detect,
    output logic                             nrzi_bypass,
    output logic                             descrambler_locked,
    output logic                             link_100_ok,
    output logic                             irq
);
    typedef struct packed {
        logic [15:0]                cfg;
        logic [7:0]                 tally;
        logic                       in_carrier;
        logic                       err_seen;
        logic                       coll_seen;
        logic [prcs_pkg::IRQ_W-1:0] irq_stat;
        logic [prcs_pkg::IRQ_W-1:0] irq_mask;
        logic                       link_prev;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
        logic                       irq;
    } prcs_regs_t;

    prcs_regs_t                 q;
    prcs_regs_t                 n;
    logic                       link_ok;
    logic                       setup;
    logic                       done;
    logic                       hit;
    logic                       rd_err;
    logic                       rd_stat;
    logic                       count_ev;
    logic                       sat_ev;
    logic [7:0]                 tally_base;
    logic [prcs_pkg::IRQ_W-1:0] ev;

    // ****************************************************************
    // link qualification
    // ****************************************************************
    prcs_link_qual #(
        .T_SHORT (DESC_SHORT_CYC),
        .T_LONG  (DESC_LONG_CYC)
    ) u_link_qual (
        .clk_sys                    (clk_sys),
        .rst_n                      (rst_n),
        .signal_level_valid         (signal_level_valid),
        .descr_sync_seen            (descr_sync_seen),
        .force_signal_detect        (q.cfg[prcs_pkg::CFG_FORCE_SD]),
        .signal_detect_algorithm    (q.cfg[prcs_pkg::CFG_SD_ALG]),
        .descrambler_timeout_select (q.cfg[prcs_pkg::CFG_DESC_TMO]),
        .force_good_link            (q.cfg[prcs_pkg::CFG_FORCE_OK]),
        .descr_locked               (descrambler_locked),
        .link_ok                    (link_ok)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        n       = q;
        // one wait state: read data is sampled in the first access cycle, pready follows
        setup   = psel & penable & ~q.pready;
        done    = psel & penable & q.pready;
        hit     = (paddr == prcs_pkg::ADR_RX_ERR) | (paddr == prcs_pkg::ADR_PCS_CFG) |
                  (paddr == prcs_pkg::ADR_IRQ_STAT) | (paddr == prcs_pkg::ADR_IRQ_MASK);
        rd_err  = setup & ~pwrite & (paddr == prcs_pkg::ADR_RX_ERR);
        rd_stat = setup & ~pwrite & (paddr == prcs_pkg::ADR_IRQ_STAT);

        // carrier event tracking: flags restart at each rising carrier
        n.in_carrier = carrier_valid;
        if (carrier_valid) begin
            if (!q.in_carrier) begin
                n.err_seen  = invalid_symbol;
                n.coll_seen = collision;
            end else begin
                n.err_seen  = q.err_seen | invalid_symbol;
                n.coll_seen = q.coll_seen | collision;
            end
        end
        // judged at the end of the event so a late collision still vetoes it
        count_ev = q.in_carrier & ~carrier_valid & q.err_seen & ~q.coll_seen;

        // clear on read and increment may meet; the increment survives
        tally_base = rd_err ? 8'h00 : q.tally;
        sat_ev     = count_ev & (tally_base == (prcs_pkg::TALLY_MAX - 8'h01));
        if (count_ev && tally_base != prcs_pkg::TALLY_MAX) begin
            n.tally = tally_base + 8'h01;
        end else begin
            n.tally = tally_base;
        end

        n.link_prev = link_ok;
        ev = '0;
        ev[prcs_pkg::IRQ_ERR_COUNT] = count_ev;
        ev[prcs_pkg::IRQ_ERR_SAT]   = sat_ev;
        ev[prcs_pkg::IRQ_LINK_CHG]  = link_ok ^ q.link_prev;
        n.irq_stat = (rd_stat ? '0 : q.irq_stat) | ev;

        // writes take effect at the completing edge
        if (done && pwrite && !q.pslverr) begin
            if (paddr == prcs_pkg::ADR_PCS_CFG) begin
                n.cfg = pwdata[15:0] & prcs_pkg::CFG_WR_MASK;
            end
            if (paddr == prcs_pkg::ADR_IRQ_MASK) begin
                n.irq_mask = pwdata[prcs_pkg::IRQ_W-1:0];
            end
        end

        n.pready  = setup;
        n.pslverr = setup & ~hit;
        if (setup) begin
            n.prdata = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    prcs_pkg::ADR_RX_ERR:   n.prdata = {24'h00_0000, q.tally};
                    prcs_pkg::ADR_PCS_CFG:  n.prdata = {16'h0000, q.cfg};
                    prcs_pkg::ADR_IRQ_STAT: n.prdata = {29'h0000_0000, q.irq_stat};
                    prcs_pkg::ADR_IRQ_MASK: n.prdata = {29'h0000_0000, q.irq_mask};
                    default:                n.prdata = 32'h0000_0000;
                endcase
            end
        end
        n.irq = |(n.irq_stat & n.irq_mask);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q     <= '0;
            q.cfg <= prcs_pkg::CFG_RESET;
        end else begin
            q <= n;
        end
    end

    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign true_quiet_enable   = q.cfg[prcs_pkg::CFG_TRUE_QUIET];
    assign force_signal_detect = q.cfg[prcs_pkg::CFG_FORCE_SD];
    assign nrzi_bypass         = q.cfg[prcs_pkg::CFG_NRZI_BYP];
    assign link_100_ok         = link_ok;
    assign irq                 = q.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_rsvd_read_zero: assert property (
        rd_err ##1 pready |-> prdata[31:8] == 24'h00_0000 && q.cfg[15:11] == 5'h00)
        else $error("reserved bits read nonzero");
    a_tally_step: assert property (
        count_ev && !rd_err && q.tally != prcs_pkg::TALLY_MAX
        |=> q.tally == $past(q.tally) + 8'h01)
        else $error("tally did not step on a counted error");
    a_tally_quiet: assert property (
        !count_ev && !rd_err |=> $stable(q.tally))
        else $error("tally moved without an ended carrier event");
    a_coll_veto: assert property (
        q.in_carrier && !carrier_valid && q.coll_seen && !rd_err |=> $stable(q.tally))
        else $error("tally stepped despite collision");
    a_tally_stick: assert property (
        q.tally == prcs_pkg::TALLY_MAX && !rd_err |=> q.tally == prcs_pkg::TALLY_MAX)
        else $error("tally wrapped");
    a_read_clear: assert property (
        rd_err && !count_ev |=> q.tally == 8'h00)
        else $error("tally not cleared by read");
    a_read_old: assert property (
        rd_err |=> prdata[7:0] == $past(q.tally) && pready)
        else $error("clearing read lost the old tally");
    a_read_keep_err: assert property (
        rd_err && count_ev |=> q.tally == 8'h01)
        else $error("error lost in clearing read cycle");
    a_cfg_outputs: assert property (
        done && pwrite && !pslverr && paddr == prcs_pkg::ADR_PCS_CFG
        |=> true_quiet_enable == $past(pwdata[10]) && force_signal_detect == $past(pwdata[9])
            && nrzi_bypass == $past(pwdata[2]))
        else $error("configuration write not reflected on outputs");
    a_alg_reset: assert property (@(posedge clk_sys)
        !$past(rst_n) |-> q.cfg == prcs_pkg::CFG_RESET)
        else $error("configuration reset value wrong");
    a_irq_follow: assert property (
        count_ev && q.irq_mask[prcs_pkg::IRQ_ERR_COUNT] |=> irq [*1])
        else $error("unmasked event did not raise irq");

    c_count: cover property (count_ev ##[1:20] rd_err);
    c_saturate: cover property (sat_ev);
    c_read_and_count: cover property (rd_err && count_ev);
endmodule
`default_nettype wire

// ---- verification/prcs_line_model.sv ----
// file: behavioural receive line model driving carrier, symbol and signal status
`timescale 1ns/1ps
`default_nettype none
module prcs_line_model (
    input  wire logic clk_sys,
    output var logic  carrier_valid,
    output var logic  invalid_symbol,
    output var logic  collision,
    output var logic  signal_level_valid,
    output var logic  descr_sync_seen
);
    initial begin
        carrier_valid = 1'h0;
        invalid_symbol = 1'h0;
        collision = 1'h0;
        signal_level_valid = 1'h0;
        descr_sync_seen = 1'h0;
    end
    // one carrier event of n cycles; with bad set the first cycle always holds a bad symbol
    task automatic send_event(input int n, input bit bad, input bit coll);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            carrier_valid <= 1'h1;
            invalid_symbol <= bad & ((i == 0) | 1'($urandom));
            collision <= coll & (i == n - 1);
        end
        @(posedge clk_sys);
        carrier_valid <= 1'h0;
        // outside a frame the symbol lines carry noise, so a stale value cannot help
        invalid_symbol <= 1'($urandom);
        collision <= 1'($urandom);
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic pulse_sync();
        @(posedge clk_sys);
        descr_sync_seen <= 1'h1;
        @(posedge clk_sys);
        descr_sync_seen <= 1'h0;
    endtask
    task automatic set_signal(input bit v);
        @(posedge clk_sys);
        signal_level_valid <= v;
    endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// file: self-checking testbench for the pcs register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {logic rd; logic err; logic [31:0] data;} prcs_note_t;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        carrier_valid, invalid_symbol, collision, signal_level_valid;
    logic        descr_sync_seen, true_quiet_enable, force_signal_detect, nrzi_bypass;
    logic        descrambler_locked, link_100_ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    prcs_note_t  notes[$];
    prcs_note_t  note;
    int          err_total = 0;
    int          cmp_count = 0;

    // short lock timeouts keep the run brief
    prcs_top #(.DESC_SHORT_CYC(20), .DESC_LONG_CYC(50)) prcs_top_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .carrier_valid(carrier_valid),
        .invalid_symbol(invalid_symbol), .collision(collision),
        .signal_level_valid(signal_level_valid), .descr_sync_seen(descr_sync_seen),
        .true_quiet_enable(true_quiet_enable), .force_signal_detect(force_signal_detect),
        .nrzi_bypass(nrzi_bypass), .descrambler_locked(descrambler_locked),
        .link_100_ok(link_100_ok), .irq(irq));
    prcs_line_model prcs_line_model_inst (
        .clk_sys(clk_sys), .carrier_valid(carrier_valid), .invalid_symbol(invalid_symbol),
        .collision(collision), .signal_level_valid(signal_level_valid),
        .descr_sync_seen(descr_sync_seen));

    // ****************************************************************
    // compare, bus and closing tasks
    // ****************************************************************
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int n;
        n = 0;
        notes.push_back('{~w, err, exp});
        @(posedge clk_sys);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            cmp_bit(1'h0, 1'h1);
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'h0, a, 32'h0, exp, err);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, 32'h0, 1'h0);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // clock, monitor, watchdog and main sequence
    // ****************************************************************
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (pready === 1'h1) begin
            if (notes.size() == 0) begin
                cmp_bit(1'h0, 1'h1);
            end else begin
                note = notes.pop_front();
                if (note.rd) begin
                    cmp_word(prdata, note.data);
                end
                cmp_bit(pslverr, note.err);
            end
        end
    end
    initial begin
        tick(20000);
        err_total++;
        complete_run();
    end
    initial begin
        void'($urandom(84));
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tick(6);
        rst_n <= 1'h1;
        rd(prcs_pkg::ADR_RX_ERR, 32'h0, 1'h0);
        rd(prcs_pkg::ADR_PCS_CFG, 32'h0100, 1'h0);
        rd(prcs_pkg::ADR_IRQ_MASK, 32'h0, 1'h0);
        wr(prcs_pkg::ADR_IRQ_MASK, 32'h1);
        prcs_line_model_inst.send_event(4, 1'b1, 1'b0);
        cmp_bit(irq, 1'h1);
        rd(prcs_pkg::ADR_IRQ_STAT, 32'h1, 1'h0);
        tick(2);
        cmp_bit(irq, 1'h0);
        rd(prcs_pkg::ADR_RX_ERR, 32'h1, 1'h0);
        rd(prcs_pkg::ADR_RX_ERR, 32'h0, 1'h0);
        prcs_line_model_inst.send_event(5, 1'b1, 1'b1);
        prcs_line_model_inst.send_event(3, 1'b0, 1'b0);
        wr(prcs_pkg::ADR_RX_ERR, 32'hFFFFFFFF);
        rd(prcs_pkg::ADR_RX_ERR, 32'h0, 1'h0);
        rd(12'h100, 32'h0, 1'h1);
        // top reserved bits and the unbuilt bit 11 written as ones; must-be-zero bits kept low
        wr(prcs_pkg::ADR_PCS_CFG, 32'hFFFFEFA4);
        rd(prcs_pkg::ADR_PCS_CFG, 32'h07A4, 1'h0);
        cmp_bit(true_quiet_enable, 1'h1);
        cmp_bit(force_signal_detect, 1'h1);
        cmp_bit(nrzi_bypass, 1'h1);
        wr(prcs_pkg::ADR_PCS_CFG, 32'h0100);
        tick(1);
        cmp_bit(true_quiet_enable | force_signal_detect | nrzi_bypass, 1'h0);
        for (int i = 0; i < 258; i++) begin
            prcs_line_model_inst.send_event(1 + int'($urandom % 4), 1'b1, 1'b0);
        end
        // the clearing read lands on the edge that counts a one-cycle carrier event
        fork
            prcs_line_model_inst.send_event(1, 1'b1, 1'b0);
            rd(prcs_pkg::ADR_RX_ERR, 32'hFF, 1'h0);
        join
        rd(prcs_pkg::ADR_RX_ERR, 32'h1, 1'h0);
        prcs_line_model_inst.set_signal(1'b1);
        prcs_line_model_inst.pulse_sync();
        tick(3);
        cmp_bit(link_100_ok, 1'h1);
        tick(30);
        cmp_bit(descrambler_locked, 1'h0);
        cmp_bit(link_100_ok, 1'h1);
        wr(prcs_pkg::ADR_PCS_CFG, 32'h0180);
        prcs_line_model_inst.pulse_sync();
        tick(30);
        cmp_bit(descrambler_locked, 1'h1);
        tick(30);
        cmp_bit(descrambler_locked, 1'h0);
        wr(prcs_pkg::ADR_PCS_CFG, 32'h0000);
        prcs_line_model_inst.pulse_sync();
        tick(3);
        cmp_bit(link_100_ok, 1'h1);
        tick(30);
        cmp_bit(link_100_ok, 1'h0);
        wr(prcs_pkg::ADR_PCS_CFG, 32'h0100);
        prcs_line_model_inst.pulse_sync();
        prcs_line_model_inst.set_signal(1'b0);
        tick(3);
        cmp_bit(link_100_ok, 1'h0);
        wr(prcs_pkg::ADR_PCS_CFG, 32'h0120);
        tick(2);
        cmp_bit(link_100_ok, 1'h1);
        complete_run();
    end
endmodule
`default_nettype wire
